// ===== tb/net_peer.sv
`timescale 1ns/1ps
module net_peer (
  input wire logic clk,
  input wire logic probe_tx,
  input wire logic [7:0] probe_node,
  output logic probe_ack,
  output logic probe_noack,
  output logic rx_pkt_valid,
  output logic [7:0] rx_pkt_socket,
  output logic [7:0] rx_pkt_sender,
  output logic [7:0] rx_pkt_len
);
  int misses = 0;
  int lag = 0;
  int sent = 0;
  int due = -1;
  logic [7:0] node_seen = 8'h00;
  initial begin
    probe_ack = 1'b0;
    probe_noack = 1'b0;
    rx_pkt_valid = 1'b0;
    rx_pkt_socket = 8'hA5;
    rx_pkt_sender = 8'h5A;
    rx_pkt_len = 8'hC3;
  end
  // answers each probe after lag cycles; a miss is a commanded no-ack
  always @(posedge clk) begin
    probe_ack <= 1'b0;
    probe_noack <= 1'b0;
    if (probe_tx === 1'b1) begin
      sent <= sent + 1;
      node_seen <= probe_node;
      due <= lag;
    end else if (due == 0) begin
      due <= -1;
      if (misses > 0) begin
        probe_noack <= 1'b1;
        misses <= misses - 1;
      end else
        probe_ack <= 1'b1;
    end else if (due > 0)
      due <= due - 1;
  end
  // one packet for one cycle, then qualifiers turn to junk
  task send_pkt(input logic [7:0] s, input logic [7:0] n, input logic [7:0] l);
    rx_pkt_socket <= s;
    rx_pkt_sender <= n;
    rx_pkt_len <= l;
    rx_pkt_valid <= 1'b1;
    @(posedge clk);
    rx_pkt_valid <= 1'b0;
    rx_pkt_socket <= ~s;
    rx_pkt_sender <= ~n;
    rx_pkt_len <= ~l;
    @(posedge clk);
  endtask : send_pkt
endmodule : net_peer

// ===== tb/test_lan_receive_command_engine.sv
`timescale 1ns/1ps
`include "lan_cmd_cfg.svh"
module test_lan_receive_command_engine;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, monitor_mode = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, rx_pkt_valid, probe_ack, probe_noack, probe_tx;
  logic host_irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, rresp_r;
  logic [31:0] s_axi_rdata, v, chain_m;
  logic [7:0] rx_pkt_socket, rx_pkt_sender, rx_pkt_len, probe_node;
  logic [7:0] tgt, b, sel, h, tail_m;
  logic [31:0] ent_m [8];
  int n_fail = 0, checks = 0, irqs = 0, cyc = 0, i0;
  int lim [5] = '{3, 3, 2, 0, 1};
  int mis [5] = '{0, 2, 3, 1, 0};

  lan_receive_command_engine #(.UNIT_CYCLES(10)) dut (
    .clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .monitor_mode, .rx_pkt_valid, .rx_pkt_socket, .rx_pkt_sender,
    .rx_pkt_len, .probe_ack, .probe_noack, .probe_tx, .probe_node, .host_irq
  );
  net_peer peer (.clk, .probe_tx, .probe_node, .probe_ack, .probe_noack,
    .rx_pkt_valid, .rx_pkt_socket, .rx_pkt_sender, .rx_pkt_len);

  always #4 clk = ~clk;

  always @(posedge clk) begin
    cyc++;
    if (host_irq === 1'b1)
      irqs++;
    if (cyc == 8000) begin
      n_fail++;
      close_out();
    end
  end

  task close_out;
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : close_out

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    @(posedge clk);
    while (s_axi_awready !== 1'b1 || s_axi_wready !== 1'b1)
      @(posedge clk);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    while (s_axi_bvalid !== 1'b1)
      @(posedge clk);
    chk({30'h0, s_axi_bresp}, {30'h0, `RESP_OKAY});
    s_axi_bready <= 1'b0;
    @(posedge clk);
  endtask : wr

  task rd(input logic [7:0] a, output logic [31:0] d);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    @(posedge clk);
    while (s_axi_arready !== 1'b1)
      @(posedge clk);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1)
      @(posedge clk);
    d = s_axi_rdata;
    rresp_r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge clk);
  endtask : rd

  task rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    rd(a, v);
    chk({30'h0, rresp_r}, {30'h0, `RESP_OKAY});
    chk(v & m, e);
  endtask : rdc

  task fin(input logic [7:0] e);
    do
      rd(`REG_RESULT, v);
    while (v[16] !== 1'b0);
    chk({24'h0, v[7:0]}, {24'h0, e});
  endtask : fin

  task cmd(input logic [31:0] w, input logic [7:0] e);
    wr(`REG_CMD, w);
    fin(e);
  endtask : cmd

  function logic [7:0] ea(input logic [7:0] i);
    return 8'h40 + {i[5:0], 2'b00};
  endfunction : ea

  // model of one stored packet, then compare descriptor state
  task pkt;
    logic [7:0] n, l;
    n = 8'($urandom);
    l = 8'($urandom);
    h = chain_m[15:8];
    i0 = irqs;
    peer.send_pkt(8'h80, n, l);
    ent_m[h][31:8] = {l, n, 8'h00};
    chain_m[15:8] = ent_m[h][7:0];
    chain_m[7:0] = (ent_m[h][7:0] == 8'h00) ? 8'hFD : 8'h00;
    tail_m = h;
    rdc(ea(h), 32'hFFFFFFFF, ent_m[h]);
    rdc(`REG_CHAIN, 32'hFFFFFFFF, chain_m);
    rdc(`REG_CHAIN2, 32'hFF, {24'h0, tail_m});
    chk(irqs - i0, 1);
  endtask : pkt

  initial begin
    void'($urandom(32'h99BC3038));
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(8'h30, v);
    chk(v, 32'h0);
    chk({30'h0, rresp_r}, {30'h0, `RESP_SLVERR});
    for (int i = 0; i < 5; i++) begin
      tgt = 8'($urandom_range(63));
      if (i == 4)
        tgt = tgt + 8'h40;
      peer.misses = mis[i];
      peer.lag = $urandom_range(3);
      peer.sent = 0;
      i0 = irqs;
      cmd({8'h00, 8'(lim[i]), tgt, 8'h03}, (i == 4) ? 8'h86 :
        (mis[i] <= lim[i]) ? 8'(mis[i]) : 8'h80);
      chk(peer.sent, (i == 4) ? 0 : (mis[i] <= lim[i]) ? mis[i] + 1 :
        lim[i] + 1);
      chk(irqs - i0, 1);
      if (i < 4)
        chk({24'h0, peer.node_seen}, {24'h0, tgt});
    end
    wr(`REG_SETUP, 32'h6);
    cmd(32'h00017001, 8'h84);
    cmd(32'h0001B001, 8'h88);
    cmd(32'h0002A001, 8'h00);
    rdc(`REG_RESULT, 32'hFF00, 32'h0000);
    repeat (30) @(posedge clk);
    rdc(`REG_RESULT, 32'hFF00, 32'h9000);
    rdc(`REG_SETUP, 32'hF, 32'h2);
    cmd(32'h00039001, 8'h00);
    peer.send_pkt(8'h90, 8'h07, 8'h10);
    rdc(`REG_RESULT, 32'hFF00, 32'h0000);
    wr(`REG_CMD, 32'h00009001);
    wr(`REG_CMD, 32'h00004003);
    rdc(`REG_RESULT, 32'h100FF, 32'h10000);
    peer.send_pkt(8'h90, 8'h07, 8'h10);
    rdc(`REG_RESULT, 32'h10000, 32'h0);
    wr(`REG_SETUP, 32'h0);
    cmd(32'h00007002, 8'h84);
    ent_m[1] = 32'h0000FF02;
    ent_m[2] = 32'h0000FF00;
    wr(ea(8'h01), ent_m[1]);
    wr(ea(8'h02), ent_m[2]);
    chain_m = 32'h010201FC;
    wr(`REG_CHAIN, chain_m);
    wr(`REG_CHAIN2, 32'h0);
    cmd(32'h00008002, 8'hFE);
    cmd(32'h00009002, 8'h85);
    cmd(32'h00038001, 8'h92);
    rdc(`REG_CHAIN2, 32'hFF, 32'h0);
    pkt();
    pkt();
    while (chain_m[31:24] != chain_m[15:8] && chain_m[31:24] != 8'h00) begin
      h = chain_m[31:24];
      chain_m[31:24] = ent_m[h][7:0];
      ent_m[h][15:0] = 16'hFF00;
      if (chain_m[15:8] != 8'h00) begin
        ent_m[chain_m[23:16]][7:0] = h;
        wr(ea(chain_m[23:16]), ent_m[chain_m[23:16]]);
      end else
        chain_m[15:8] = h;
      chain_m[23:16] = h;
      wr(ea(h), ent_m[h]);
    end
    chain_m[7:0] = 8'hFC;
    wr(`REG_CHAIN, chain_m);
    pkt();
    pkt();
    for (int s = 0; s < 2; s++) begin
      sel = s ? 8'h04 : 8'h02;
      wr(`REG_CMD, {8'h00, sel, 8'h02, 8'h04});
      repeat (2) begin
        b = 8'($urandom);
        wr(`REG_LB_DATA, {24'h0, b});
      end
      fin(8'h00);
      rdc(`REG_LB_DATA, 32'hFF, {24'h0, b});
      if (s == 0)
        rdc(`REG_LB_CSUM, 32'hFFFF0000, 32'h0);
    end
    monitor_mode <= 1'b1;
    @(posedge clk);
    for (int op = 1; op < 5; op++) begin
      i0 = irqs;
      cmd({8'h00, 16'h0105, 8'(op)}, 8'h8A);
      chk(irqs - i0, 1);
    end
    close_out();
  end
endmodule : test_lan_receive_command_engine

// ===== verilog/lan_cmd_cfg.svh
// Operation
// [RL1] wait lasts wait code times 100 ms
// [RL2] zero wait code blocks commands until packet
// [RL3] timed wait answers 00, 84, 88 or 92
// [RL4] wait ends 00 on packet, 90 and deactivate
// [RL5] receive chain takes only sockets 80, 90
// [RL6] receive chain answers FE, or 85 if used
// [RL7] packet stored at free head, slot marked full
// [RL8] advance free head, set filled tail, state 00
// [RL9] last free buffer gives state FD, head 00
// [RL10] slot FF empty, 00 full; link 00 ends
// [RL11] host marks slots FF on issue and reuse
// [RL12] host consumes only on state 00 or FD
// [RL13] host takes filled head, relinks, frees slot
// [RL14] host appends freed entry to free chain
// [RL15] host repeats until empty, then writes FC
// [RL16] filled tail 00 means nothing received yet
// [RL17] probe retransmits up to retry limit times
// [RL18] probe reports retry count or 80 exhausted
// [RL19] probe target 40 or above gives 86
// [RL20] loop-back checksum 16 bit on 02, 32 on 04
// [RL21] loop-back echoes bytes, checksum, answers 00
// [RL22] monitor mode refuses these commands with 8A
// [RL23] interrupt on every completion code write
// [RL24] monitor mode stops ordinary work; the code only refuses new commands, running waits and chain reception go on
// [RL25] wait unit divided from the system clock
`ifndef LAN_CMD_CFG_SVH
`define LAN_CMD_CFG_SVH
`define REG_CMD 8'h00
`define REG_RESULT 8'h04
`define REG_CHAIN 8'h08
`define REG_CHAIN2 8'h0C
`define REG_SETUP 8'h10
`define REG_LB_DATA 8'h14
`define REG_LB_CSUM 8'h18
`define ENTRY_PAGE 3'h2
`define CC_OK 8'h00
`define CC_EXHAUST 8'h80
`define CC_BAD_SOCK 8'h84
`define CC_IN_USE 8'h85
`define CC_BAD_NODE 8'h86
`define CC_NOT_SETUP 8'h88
`define CC_MONITOR 8'h8A
`define CC_TIMEOUT 8'h90
`define CC_LIST_OWNED 8'h92
`define CC_LIST_READY 8'hFE
`define BUF_NEW 8'h00
`define BUF_FULL 8'hFD
`define SLOT_FULL 8'h00
`define LINK_END 8'h00
`define SOCK_LIST0 8'h80
`define SOCK_LIST1 8'h90
`define NODE_LIMIT 8'h40
`define CSUM_WIDE 8'h04
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define WAIT_UNIT_MS 100
`define CLK_KHZ 125000
`define WAIT_UNIT_CYCLES (`WAIT_UNIT_MS * `CLK_KHZ)
`endif

// ===== verilog/lan_cmd_pkg.sv
package lan_cmd_pkg;
  typedef enum logic [7:0] {
    OP_WAIT = 8'h01,
    OP_CHAIN = 8'h02,
    OP_PROBE = 8'h03,
    OP_LOOP = 8'h04
  } op_t;
  typedef enum logic [1:0] {
    ENG_IDLE = 2'b00,
    ENG_SEND = 2'b01,
    ENG_ACK = 2'b10,
    ENG_LOOP = 2'b11
  } eng_t;
endpackage : lan_cmd_pkg

// ===== verilog/lan_receive_command_engine.sv
// The AXI4-Lite interface to the registers and the address map were decided locally.
`timescale 1ns/1ps
`include "lan_cmd_cfg.svh"
module lan_receive_command_engine #(
  parameter int unsigned UNIT_CYCLES = `WAIT_UNIT_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic monitor_mode,
  input wire logic rx_pkt_valid,
  input wire logic [7:0] rx_pkt_socket,
  input wire logic [7:0] rx_pkt_sender,
  input wire logic [7:0] rx_pkt_len,
  input wire logic probe_ack,
  input wire logic probe_noack,
  output logic probe_tx,
  output logic [7:0] probe_node,
  output logic host_irq
);
  logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r, irq_r;
  logic [1:0] bresp_r, rresp_r;
  logic [31:0] rdata_r, rd_nxt;
  logic wr_en, wr_cmd, busy, cmd_go;
  logic [7:0] op, arg, prm;
  logic [7:0] result_r, wait_res_r;
  logic res_we, res2_we;
  logic [7:0] res_val, res2_val;
  logic start_wait, start_chain, start_probe, start_loop;
  logic [3:0] setup_r;
  logic wait_act_r, wait_zero_r;
  logic [1:0] wait_idx_r;
  logic [7:0] wait_units_r;
  logic [31:0] tick_r;
  logic wait_hit, wait_tmo;
  logic chain_act_r, chain_sel_r, chain_hit;
  logic [7:0] bstate_r, fh_r, ft_r, rh_r, rt_r;
  logic [7:0] link_m [8];
  logic [7:0] occ_m [8];
  logic [7:0] src_m [8];
  logic [7:0] len_m [8];
  lan_cmd_pkg::eng_t eng_r;
  logic [6:0] lim_r, tries_r;
  logic [7:0] node_r, lb_left_r, echo_r;
  logic lb_wide_r, probe_tx_r, probe_done, loop_done;
  logic [31:0] csum_r;

  function automatic logic sock_ok(input logic [7:0] s);
    sock_ok = (s[7:6] == 2'b10) && (s[3:0] == 4'h0);
  endfunction : sock_ok

  function automatic logic [31:0] merge(input logic [31:0] o,
      input logic [31:0] n, input logic [3:0] s);
    for (int i = 0; i < 4; i++)
      merge[i*8 +: 8] = s[i] ? n[i*8 +: 8] : o[i*8 +: 8];
  endfunction : merge

  function automatic logic is_entry(input logic [7:0] a);
    is_entry = (a[7:5] == `ENTRY_PAGE) && (a[1:0] == 2'b00);
  endfunction : is_entry

  function automatic logic mapped(input logic [7:0] a);
    mapped = is_entry(a) || ((a[1:0] == 2'b00) && (a <= `REG_LB_CSUM));
  endfunction : mapped

  function automatic logic [31:0] csum_step(input logic [31:0] c,
      input logic [7:0] b, input logic w);
    if (w)
      csum_step = {c[30:0], c[31]} ^ {24'h000000, b};
    else
      csum_step = {16'h0000, c[14:0], c[15]} ^ {24'h000000, b};
  endfunction : csum_step

  // bus slave: write address and data taken together
  assign wr_en = awready_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= `RESP_OKAY;
    end else begin
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      if (bvalid_r && s_axi_bready)
        bvalid_r <= 1'b0;
      if (s_axi_awvalid && s_axi_wvalid && !awready_r && !bvalid_r) begin
        awready_r <= 1'b1;
        wready_r <= 1'b1;
      end
      if (awready_r) begin
        bvalid_r <= 1'b1;
        bresp_r <= mapped(s_axi_awaddr) ? `RESP_OKAY : `RESP_SLVERR;
      end
    end
  end

  always_comb begin
    rd_nxt = 32'h00000000;
    if (is_entry(s_axi_araddr))
      rd_nxt = {len_m[s_axi_araddr[4:2]], src_m[s_axi_araddr[4:2]],
                occ_m[s_axi_araddr[4:2]], link_m[s_axi_araddr[4:2]]};
    else
      case (s_axi_araddr)
        `REG_RESULT: rd_nxt = {15'h0000, busy, wait_res_r, result_r};
        `REG_CHAIN: rd_nxt = {rh_r, ft_r, fh_r, bstate_r};
        `REG_CHAIN2: rd_nxt = {14'h0000, chain_sel_r, chain_act_r,
                               8'h00, rt_r};
        `REG_SETUP: rd_nxt = {28'h0000000, setup_r};
        `REG_LB_DATA: rd_nxt = {24'h000000, echo_r};
        `REG_LB_CSUM: rd_nxt = csum_r;
        default: rd_nxt = 32'h00000000;
      endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h00000000;
      rresp_r <= `RESP_OKAY;
    end else begin
      arready_r <= s_axi_arvalid && !arready_r && !rvalid_r;
      if (rvalid_r && s_axi_rready)
        rvalid_r <= 1'b0;
      if (arready_r) begin
        rvalid_r <= 1'b1;
        rdata_r <= rd_nxt;
        rresp_r <= mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
      end
    end
  end

  // command decode and immediate completion codes
  assign busy = wait_zero_r || (eng_r != lan_cmd_pkg::ENG_IDLE);
  assign wr_cmd = wr_en && (s_axi_awaddr == `REG_CMD);
  assign cmd_go = wr_cmd && !busy; // [RL2]
  assign op = s_axi_wdata[7:0];
  assign arg = s_axi_wdata[15:8];
  assign prm = s_axi_wdata[23:16];
  always_comb begin
    res_we = 1'b0;
    res_val = `CC_OK;
    start_wait = 1'b0;
    start_chain = 1'b0;
    start_probe = 1'b0;
    start_loop = 1'b0;
    if (cmd_go) begin
      res_we = 1'b1;
      if (monitor_mode)
        res_val = `CC_MONITOR; // [RL22] [RL24]
      else
        case (op)
          lan_cmd_pkg::OP_WAIT: begin
            if (!sock_ok(arg))
              res_val = `CC_BAD_SOCK; // [RL3]
            else if (chain_act_r && arg[5:4] == {1'b0, chain_sel_r})
              res_val = `CC_LIST_OWNED; // [RL3]
            else if (!setup_r[arg[5:4]])
              res_val = `CC_NOT_SETUP; // [RL3]
            else
              start_wait = 1'b1;
          end
          lan_cmd_pkg::OP_CHAIN: begin
            if (arg != `SOCK_LIST0 && arg != `SOCK_LIST1)
              res_val = `CC_BAD_SOCK; // [RL5]
            else if (chain_act_r || setup_r[arg[5:4]])
              res_val = `CC_IN_USE; // [RL6]
            else begin
              res_val = `CC_LIST_READY; // [RL6]
              start_chain = 1'b1;
            end
          end
          lan_cmd_pkg::OP_PROBE: begin
            res_we = (arg >= `NODE_LIMIT);
            res_val = `CC_BAD_NODE; // [RL19]
            start_probe = !res_we;
          end
          lan_cmd_pkg::OP_LOOP: begin
            res_we = 1'b0;
            start_loop = 1'b1;
          end
          default: res_we = 1'b0;
        endcase
    end
    if (probe_done) begin
      res_we = 1'b1;
      res_val = probe_ack ? {1'b0, tries_r} : `CC_EXHAUST; // [RL18]
    end
    if (loop_done) begin
      res_we = 1'b1;
      res_val = `CC_OK; // [RL21]
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      result_r <= `CC_OK;
      wait_res_r <= `CC_OK;
      irq_r <= 1'b0;
    end else begin
      irq_r <= res_we || res2_we || chain_hit; // [RL23] [RL8]
      if (res_we)
        result_r <= res_val;
      if (res2_we)
        wait_res_r <= res2_val;
    end
  end

  // timed wait, unit divided from the system clock
  assign wait_hit = wait_act_r && rx_pkt_valid && sock_ok(rx_pkt_socket)
                    && rx_pkt_socket[5:4] == wait_idx_r;
  assign wait_tmo = wait_act_r && !wait_zero_r && !wait_hit
                    && tick_r == UNIT_CYCLES - 1 && wait_units_r == 8'h01;
  assign res2_we = wait_hit || wait_tmo;
  assign res2_val = wait_hit ? `CC_OK : `CC_TIMEOUT; // [RL4]
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_act_r <= 1'b0;
      wait_zero_r <= 1'b0;
      wait_idx_r <= 2'h0;
      wait_units_r <= 8'h00;
      tick_r <= 32'h00000000;
    end else if (start_wait) begin
      wait_act_r <= 1'b1;
      wait_zero_r <= (prm == 8'h00); // [RL2]
      wait_idx_r <= arg[5:4];
      wait_units_r <= prm;
      tick_r <= 32'h00000000;
    end else if (res2_we) begin
      wait_act_r <= 1'b0;
      wait_zero_r <= 1'b0;
    end else if (wait_act_r && !wait_zero_r) begin
      if (tick_r == UNIT_CYCLES - 1) begin // [RL25]
        tick_r <= 32'h00000000;
        wait_units_r <= wait_units_r - 8'h01; // [RL1]
      end else
        tick_r <= tick_r + 32'h00000001;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      setup_r <= 4'h0;
    else if (wait_tmo)
      setup_r[wait_idx_r] <= 1'b0; // [RL4]
    else if (wr_en && s_axi_awaddr == `REG_SETUP && s_axi_wstrb[0])
      setup_r <= s_axi_wdata[3:0];
  end

  // receive chain: hardware updates win over software writes
  assign chain_hit = chain_act_r && rx_pkt_valid && fh_r != `LINK_END
      && rx_pkt_socket == (chain_sel_r ? `SOCK_LIST1 : `SOCK_LIST0);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      chain_act_r <= 1'b0;
      chain_sel_r <= 1'b0;
      {rh_r, ft_r, fh_r, bstate_r} <= 32'h00000000;
      rt_r <= 8'h00;
      for (int i = 0; i < 8; i++) begin
        link_m[i] <= 8'h00;
        occ_m[i] <= 8'h00;
        src_m[i] <= 8'h00;
        len_m[i] <= 8'h00;
      end
    end else begin
      if (start_chain) begin
        chain_act_r <= 1'b1;
        chain_sel_r <= arg[4];
      end
      if (wr_en && is_entry(s_axi_awaddr))
        {len_m[s_axi_awaddr[4:2]], src_m[s_axi_awaddr[4:2]],
         occ_m[s_axi_awaddr[4:2]], link_m[s_axi_awaddr[4:2]]} <=
          merge({len_m[s_axi_awaddr[4:2]], src_m[s_axi_awaddr[4:2]],
                 occ_m[s_axi_awaddr[4:2]], link_m[s_axi_awaddr[4:2]]},
                s_axi_wdata, s_axi_wstrb);
      if (wr_en && s_axi_awaddr == `REG_CHAIN)
        {rh_r, ft_r, fh_r, bstate_r} <=
          merge({rh_r, ft_r, fh_r, bstate_r}, s_axi_wdata, s_axi_wstrb);
      if (wr_en && s_axi_awaddr == `REG_CHAIN2 && s_axi_wstrb[0])
        rt_r <= s_axi_wdata[7:0];
      if (chain_hit) begin
        occ_m[fh_r[2:0]] <= `SLOT_FULL; // [RL7] [RL10]
        src_m[fh_r[2:0]] <= rx_pkt_sender; // [RL7]
        len_m[fh_r[2:0]] <= rx_pkt_len; // [RL7]
        rt_r <= fh_r; // [RL8] [RL16]
        fh_r <= link_m[fh_r[2:0]]; // [RL8] [RL9]
        bstate_r <= (link_m[fh_r[2:0]] == `LINK_END) ?
                    `BUF_FULL : `BUF_NEW; // [RL9] [RL8]
      end
    end
  end

  // probe and loop-back engine
  assign probe_done = (eng_r == lan_cmd_pkg::ENG_ACK)
      && (probe_ack || (probe_noack && tries_r == lim_r)); // [RL17]
  assign loop_done = (eng_r == lan_cmd_pkg::ENG_LOOP) && lb_left_r == 8'h00;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      eng_r <= lan_cmd_pkg::ENG_IDLE;
      lim_r <= 7'h00;
      tries_r <= 7'h00;
      node_r <= 8'h00;
      probe_tx_r <= 1'b0;
      lb_left_r <= 8'h00;
      lb_wide_r <= 1'b0;
      csum_r <= 32'h00000000;
      echo_r <= 8'h00;
    end else begin
      probe_tx_r <= 1'b0;
      case (eng_r)
        lan_cmd_pkg::ENG_IDLE: begin
          if (start_probe) begin
            lim_r <= prm[6:0]; // [RL17]
            tries_r <= 7'h00;
            node_r <= arg;
            eng_r <= lan_cmd_pkg::ENG_SEND;
          end else if (start_loop) begin
            lb_left_r <= arg;
            lb_wide_r <= (prm == `CSUM_WIDE); // [RL20]
            csum_r <= 32'h00000000;
            eng_r <= lan_cmd_pkg::ENG_LOOP;
          end
        end
        lan_cmd_pkg::ENG_SEND: begin
          probe_tx_r <= 1'b1;
          eng_r <= lan_cmd_pkg::ENG_ACK;
        end
        lan_cmd_pkg::ENG_ACK: begin
          if (probe_done)
            eng_r <= lan_cmd_pkg::ENG_IDLE;
          else if (probe_noack) begin
            tries_r <= tries_r + 7'h01; // [RL17]
            eng_r <= lan_cmd_pkg::ENG_SEND;
          end
        end
        lan_cmd_pkg::ENG_LOOP: begin
          if (loop_done)
            eng_r <= lan_cmd_pkg::ENG_IDLE;
          else if (wr_en && s_axi_awaddr == `REG_LB_DATA) begin
            echo_r <= s_axi_wdata[7:0]; // [RL21]
            csum_r <= csum_step(csum_r, s_axi_wdata[7:0], lb_wide_r);
            lb_left_r <= lb_left_r - 8'h01;
          end
        end
        default: eng_r <= lan_cmd_pkg::ENG_IDLE;
      endcase
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign probe_tx = probe_tx_r;
  assign probe_node = node_r;
  assign host_irq = irq_r;

  default clocking dc @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_zero_wait;
    cmd_go && op == lan_cmd_pkg::OP_WAIT && sock_ok(arg) && !monitor_mode
      && setup_r[arg[5:4]] && !chain_act_r && prm == 8'h00;
  endsequence
  a_zero_wait_busy: assert property (s_zero_wait |=> busy [*3]) // [RL2]
    else $error("zero wait did not hold busy");
  a_wait_timeout: assert property (wait_tmo |=> // [RL4]
      wait_res_r == `CC_TIMEOUT && !setup_r[$past(wait_idx_r)] && host_irq)
    else $error("timeout code or deactivate missing");
  a_chain_bad_sock: assert property (cmd_go && !monitor_mode // [RL5]
      && op == lan_cmd_pkg::OP_CHAIN && arg != `SOCK_LIST0
      && arg != `SOCK_LIST1 |=> result_r == `CC_BAD_SOCK)
    else $error("bad chain socket not refused");
  a_store_advance: assert property (chain_hit |=> fh_r == // [RL8]
      $past(link_m[fh_r[2:0]]) && rt_r == $past(fh_r))
    else $error("chain indexes not advanced");
  a_last_buffer: assert property (chain_hit && link_m[fh_r[2:0]] == // [RL9]
      `LINK_END |=> bstate_r == `BUF_FULL && fh_r == 8'h00)
    else $error("last buffer not flagged full");
  a_probe_bad_node: assert property (cmd_go && !monitor_mode // [RL19]
      && op == lan_cmd_pkg::OP_PROBE && arg >= `NODE_LIMIT
      |=> result_r == `CC_BAD_NODE && !probe_tx [*2])
    else $error("bad probe target not refused");
  a_monitor_refuse: assert property (cmd_go && monitor_mode // [RL22]
      |=> result_r == `CC_MONITOR && !$rose(wait_act_r)
      && !$rose(chain_act_r) && eng_r == lan_cmd_pkg::ENG_IDLE)
    else $error("command ran in monitor mode");
  a_irq_on_code: assert property (res_we |=> host_irq) // [RL23]
    else $error("completion without interrupt");
  a_probe_exhaust: assert property (probe_done && !probe_ack // [RL18]
      |=> result_r == `CC_EXHAUST ##1 !probe_tx)
    else $error("exhausted probe misreported");
endmodule : lan_receive_command_engine
